// ### mmbcs_device.sv
// Notes on behaviour
// - Status valid at clock high of T4, T1, T2.
// - Passive code in T3, or wait with ready.
// - Leaving passive during T4 starts a cycle.
// - Returning to passive in T3/wait ends cycle.
// - Status floats during hold acknowledge.
// - First clock of reset drives high, then float.
// - Eight status encodings, passive all ones.
// - Controller derives strobes from decoded status.
`include "mmbcs_defines.svh"
`default_nettype none
module mmbcs_device
	import mmbcs_pkg::*;
#(
	parameter int CLK_DIV = `MMBCS_CLK_DIV_DEFAULT
)
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic cpu_reset,
	input wire logic cycle_req,
	input wire logic [2:0] cycle_kind,
	input wire logic hold_req,
	output logic cycle_busy,
	output logic hold_ack,
	mmbcs_if.device bus
);
	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	// The divider needs two fast clocks per slow clock to show both phases.
	if (CLK_DIV < 2 || CLK_DIV % 2 != 0)
	begin : g_bad_div
		$error("CLK_DIV must be even and at least 2");
	end

	// The phase counter is eight bits wide, so half a slow clock may not exceed 256 fast clocks.
	if (CLK_DIV > 512)
	begin : g_big_div
		$error("CLK_DIV must not exceed 512");
	end

	localparam int HALF = CLK_DIV / 2;

	typedef struct packed
	{
		logic [7:0] div;
		logic high;
		mmbcs_tstate_e tst;
		logic [2:0] code;
		logic pend;
		logic busy;
		logic hlda;
		logic rst_first;
		logic in_rst;
		logic [2:0] st;
		logic oe;
	} mmbcs_dev_s;

	mmbcs_dev_s r_q;
	mmbcs_dev_s r_d;
	logic tick_fall;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// The slow processor clock is a phase bit toggled by the divider; T-states advance on its falling edge,
	// so a status change made there is settled for the whole following high half; the controller samples on every fast clock.
	always_comb
	begin
		r_d = r_q;
		tick_fall = 1'b0;
		if (r_q.div == 8'(HALF - 1))
		begin
			r_d.div = 8'h00;
			r_d.high = ~r_q.high;
			tick_fall = r_q.high;
		end
		else
		begin
			r_d.div = r_q.div + 8'h01;
		end
		if (cpu_reset)
		begin
			// Drive ones for the first slow clock of reset, then float.
			if (!r_q.in_rst)
			begin
				r_d.in_rst = 1'b1;
				r_d.rst_first = 1'b1;
				r_d.st = `MMBCS_CODE_PASSIVE;
				r_d.oe = 1'b1;
			end
			else if (tick_fall && r_q.rst_first)
			begin
				r_d.rst_first = 1'b0;
				r_d.oe = 1'b0;
			end
			r_d.tst = MMBCS_TI;
			r_d.busy = 1'b0;
			r_d.hlda = 1'b0;
			r_d.pend = 1'b0;
		end
		else
		begin
			r_d.in_rst = 1'b0;
			r_d.rst_first = 1'b0;
			if (r_q.in_rst)
			begin
				r_d.oe = 1'b1;
				r_d.st = `MMBCS_CODE_PASSIVE;
			end
			if (tick_fall)
			begin
				case (r_q.tst)
					MMBCS_TI, MMBCS_T4:
					begin
						if (r_q.pend)
						begin
							// A code already shown in T4 always runs; a hold waits for the next T4.
							r_d.pend = 1'b0;
							r_d.st = r_q.code;
							r_d.tst = MMBCS_T1;
						end
						else if (hold_req)
						begin
							r_d.tst = MMBCS_THOLD;
							r_d.hlda = 1'b1;
							r_d.oe = 1'b0;
							r_d.busy = 1'b0;
						end
						else if (r_q.oe && cycle_req && cycle_kind != `MMBCS_CODE_PASSIVE)
						begin
							// Leaving passive on entry to a lead-in T4 keeps the code valid in its high half.
							// Waiting until the lines are driven means a drive never starts off passive.
							r_d.code = cycle_kind;
							r_d.st = cycle_kind;
							r_d.tst = MMBCS_T4;
							r_d.pend = 1'b1;
							r_d.busy = 1'b1;
							r_d.oe = 1'b1;
						end
						else
						begin
							r_d.st = `MMBCS_CODE_PASSIVE;
							r_d.tst = MMBCS_TI;
							r_d.busy = 1'b0;
							r_d.oe = 1'b1;
						end
					end
					MMBCS_T1:
					begin
						r_d.st = r_q.code;
						r_d.tst = MMBCS_T2;
					end
					MMBCS_T2:
					begin
						r_d.tst = MMBCS_T3;
						r_d.st = `MMBCS_CODE_PASSIVE;
					end
					MMBCS_T3, MMBCS_TW:
					begin
						r_d.st = `MMBCS_CODE_PASSIVE;
						r_d.tst = bus.ready ? MMBCS_T4 : MMBCS_TW;
						// Back to back, the next code leaves passive on entry to T4, after a whole passive T3.
						if (bus.ready && cycle_req && !hold_req && cycle_kind != `MMBCS_CODE_PASSIVE)
						begin
							r_d.code = cycle_kind;
							r_d.st = cycle_kind;
							r_d.pend = 1'b1;
						end
					end
					MMBCS_THOLD:
					begin
						if (!hold_req)
						begin
							r_d.hlda = 1'b0;
							r_d.tst = MMBCS_TI;
							r_d.oe = 1'b1;
							r_d.st = `MMBCS_CODE_PASSIVE;
						end
					end
					default:
					begin
						r_d.tst = MMBCS_TI;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// Power-up floats the status lines until the first slow falling edge drives them passive.
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			r_q <= '{div: 8'h00, high: 1'b0, tst: MMBCS_TI, code: `MMBCS_CODE_PASSIVE,
				pend: 1'b0, busy: 1'b0, hlda: 1'b0, rst_first: 1'b0, in_rst: 1'b0,
				st: `MMBCS_CODE_PASSIVE, oe: 1'b0};
		end
		else
		begin
			r_q <= r_d;
		end
	end

	// Outputs come straight from the state flops.
	assign bus.cycle_status_bit2 = r_q.st[2];
	assign bus.cycle_status_bit1 = r_q.st[1];
	assign bus.cycle_status_bit0 = r_q.st[0];
	assign bus.status_oe = r_q.oe;
	assign bus.clk_high = r_q.high;
	assign cycle_busy = r_q.busy;
	assign hold_ack = r_q.hlda;
endmodule
`default_nettype wire

// ### mmbcs_defines.svh
`ifndef MMBCS_DEFINES_SVH
`define MMBCS_DEFINES_SVH
// ----------------------------------------
// Status codes
// ----------------------------------------
`define MMBCS_CODE_INTA 3'h0
`define MMBCS_CODE_IORD 3'h1
`define MMBCS_CODE_IOWR 3'h2
`define MMBCS_CODE_HALT 3'h3
`define MMBCS_CODE_FETCH 3'h4
`define MMBCS_CODE_MRD 3'h5
`define MMBCS_CODE_MWR 3'h6
`define MMBCS_CODE_PASSIVE 3'h7
// ----------------------------------------
// Timing counts
// ----------------------------------------
`define MMBCS_CLK_DIV_DEFAULT 4
`define MMBCS_RESET_DRIVE_CLKS 1
`endif

// ### mmbcs_pkg.sv
`default_nettype none
package mmbcs_pkg;
	// Bus cycle kinds, in code order.
	typedef enum logic [2:0]
	{
		MMBCS_INTA,
		MMBCS_IORD,
		MMBCS_IOWR,
		MMBCS_HALT,
		MMBCS_FETCH,
		MMBCS_MRD,
		MMBCS_MWR,
		MMBCS_NONE
	} mmbcs_kind_e;
	// Processor bus T-states.
	typedef enum logic [2:0]
	{
		MMBCS_TI,
		MMBCS_T1,
		MMBCS_T2,
		MMBCS_T3,
		MMBCS_TW,
		MMBCS_T4,
		MMBCS_THOLD
	} mmbcs_tstate_e;
endpackage
`default_nettype wire

// ### mmbcs_if.sv
`default_nettype none
interface mmbcs_if;
	// Status bits and output enable of the device end.
	logic cycle_status_bit2;
	logic cycle_status_bit1;
	logic cycle_status_bit0;
	logic status_oe;
	// Ready returned by the system, sampled by the device.
	logic ready;
	// Processor clock phase, high half of the slow clock.
	logic clk_high;
	modport device
	(
		output cycle_status_bit2,
		output cycle_status_bit1,
		output cycle_status_bit0,
		output status_oe,
		output clk_high,
		input ready
	);
	modport controller
	(
		input cycle_status_bit2,
		input cycle_status_bit1,
		input cycle_status_bit0,
		input status_oe,
		input clk_high,
		output ready
	);
endinterface
`default_nettype wire

// ### mmbcs_controller.sv
`include "mmbcs_defines.svh"
`default_nettype none
module mmbcs_controller
	import mmbcs_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ready_in,
	output logic cycle_start,
	output logic cycle_end,
	output logic [2:0] cycle_kind,
	output logic mem_rd_cmd,
	output logic mem_wr_cmd,
	output logic io_rd_cmd,
	output logic io_wr_cmd,
	output logic inta_cmd,
	mmbcs_if.controller bus
);
	typedef struct packed
	{
		logic [2:0] prev;
		logic [2:0] kind;
		logic active;
		logic start;
		logic fin;
		logic [4:0] cmd;
		logic rdy;
	} mmbcs_ctl_s;

	mmbcs_ctl_s r_q;
	mmbcs_ctl_s r_d;
	logic [2:0] st_now;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// A floated bus reads as passive, so hold acknowledge never looks like a cycle.
	always_comb
	begin
		st_now = bus.status_oe ? {bus.cycle_status_bit2, bus.cycle_status_bit1, bus.cycle_status_bit0}
			: `MMBCS_CODE_PASSIVE;
		r_d = r_q;
		r_d.start = 1'b0;
		r_d.fin = 1'b0;
		r_d.rdy = ready_in;
		r_d.prev = st_now;
		if (r_q.prev == `MMBCS_CODE_PASSIVE && st_now != `MMBCS_CODE_PASSIVE)
		begin
			r_d.start = 1'b1;
			r_d.active = 1'b1;
			r_d.kind = st_now;
			// Command strobes come only from the decoded code.
			case (st_now)
				`MMBCS_CODE_INTA: r_d.cmd = 5'h10;
				`MMBCS_CODE_IORD: r_d.cmd = 5'h04;
				`MMBCS_CODE_IOWR: r_d.cmd = 5'h08;
				`MMBCS_CODE_FETCH, `MMBCS_CODE_MRD: r_d.cmd = 5'h01;
				`MMBCS_CODE_MWR: r_d.cmd = 5'h02;
				default: r_d.cmd = 5'h00; // Halt issues no strobe.
			endcase
		end
		else if (r_q.active && st_now == `MMBCS_CODE_PASSIVE)
		begin
			r_d.fin = 1'b1;
			r_d.active = 1'b0;
			r_d.cmd = 5'h00;
		end
	end

	// Controller state, cleared to idle.
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			r_q <= '{prev: `MMBCS_CODE_PASSIVE, kind: `MMBCS_CODE_PASSIVE, active: 1'b0, start: 1'b0,
				fin: 1'b0, cmd: 5'h00, rdy: 1'b0};
		end
		else
		begin
			r_q <= r_d;
		end
	end

	assign bus.ready = r_q.rdy;
	assign cycle_start = r_q.start;
	assign cycle_end = r_q.fin;
	assign cycle_kind = r_q.kind;
	assign mem_rd_cmd = r_q.cmd[0];
	assign mem_wr_cmd = r_q.cmd[1];
	assign io_rd_cmd = r_q.cmd[2];
	assign io_wr_cmd = r_q.cmd[3];
	assign inta_cmd = r_q.cmd[4];
endmodule
`default_nettype wire

// ### mmbcs_assertions.sv
`default_nettype none
module mmbcs_assertions
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic cycle_status_bit2,
	input wire logic cycle_status_bit1,
	input wire logic cycle_status_bit0,
	input wire logic status_oe,
	input wire logic clk_high,
	input wire logic hold_ack,
	input wire logic cycle_start,
	input wire logic cycle_end
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------
	// Status checks
	// ----------
	// Packed status, most significant bit first.
	wire [2:0] s = {cycle_status_bit2, cycle_status_bit1, cycle_status_bit0};
	default clocking @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	// Changes in the low half keep every high half clean for the decoder.
	chg_low_a: assert property (status_oe && $past(status_oe) && s != $past(s) |-> !clk_high)
		else $error("status moved in clock high");
	code_hold_a: assert property ($past(s) == 3'h7 && s != 3'h7 && status_oe |-> ##1 $stable(s) [*7])
		else $error("code did not stand");
	start_lag_a: assert property ($past(s) == 3'h7 && s != 3'h7 && status_oe |-> ##1 cycle_start)
		else $error("start not seen");
	start_cause_a: assert property (cycle_start |-> $past(s) != 3'h7 && $past(s, 2) == 3'h7)
		else $error("start without code");
	end_lag_a: assert property ($past(s) != 3'h7 && s == 3'h7 && status_oe && $past(status_oe) |-> ##1 cycle_end)
		else $error("end not seen");
	end_cause_a: assert property (cycle_end |-> $past(s) == 3'h7 && $past(s, 2) != 3'h7)
		else $error("end without passive");
	hold_float_a: assert property (hold_ack |-> !status_oe)
		else $error("status driven in hold");
	drive_passive_a: assert property ($rose(status_oe) |-> s == 3'h7)
		else $error("drive began off passive");
	cover property (cycle_start);
	cover property (cycle_end);
	cover property (hold_ack);
endmodule
`default_nettype wire

// ### tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0, sys_rst = 1'b1, cpu_reset = 1'b0, cycle_req = 1'b0, hold_req = 1'b0, ready_in = 1'b1;
	logic [2:0] dev_kind = 3'h7;
	logic [2:0] ctl_kind;
	logic cycle_busy, hold_ack, cycle_start, cycle_end, mrd, mwr, ird, iwr, ack;
	int failures = 0, cmp_count = 0, cycles = 0;
	// Strobes in the order mem read, mem write, io read, io write, acknowledge.
	logic [4:0] tab [7] = '{5'h01, 5'h04, 5'h02, 5'h00, 5'h10, 5'h10, 5'h08};
	mmbcs_if mmbcs_if_i();
	wire [3:0] bs = {mmbcs_if_i.status_oe, mmbcs_if_i.cycle_status_bit2, mmbcs_if_i.cycle_status_bit1,
		mmbcs_if_i.cycle_status_bit0};
	wire [4:0] cmds = {mrd, mwr, ird, iwr, ack};
	mmbcs_device #(.CLK_DIV(4)) mmbcs_device_i (.clock(clock), .sys_rst(sys_rst), .cpu_reset(cpu_reset),
		.cycle_req(cycle_req), .cycle_kind(dev_kind), .hold_req(hold_req), .cycle_busy(cycle_busy),
		.hold_ack(hold_ack), .bus(mmbcs_if_i));
	mmbcs_controller mmbcs_controller_i (.clock(clock), .sys_rst(sys_rst), .ready_in(ready_in),
		.cycle_start(cycle_start), .cycle_end(cycle_end), .cycle_kind(ctl_kind), .mem_rd_cmd(mrd),
		.mem_wr_cmd(mwr), .io_rd_cmd(ird), .io_wr_cmd(iwr), .inta_cmd(ack), .bus(mmbcs_if_i));
	mmbcs_assertions mmbcs_assertions_i (.clock(clock), .sys_rst(sys_rst),
		.cycle_status_bit2(mmbcs_if_i.cycle_status_bit2), .cycle_status_bit1(mmbcs_if_i.cycle_status_bit1),
		.cycle_status_bit0(mmbcs_if_i.cycle_status_bit0), .status_oe(mmbcs_if_i.status_oe),
		.clk_high(mmbcs_if_i.clk_high), .hold_ack(hold_ack), .cycle_start(cycle_start), .cycle_end(cycle_end));
	// ----------
	// Tasks
	// ----------
	// Inputs move 1 ns after the edge, so no race with the sampling edge.
	task automatic tick();
		@(posedge clock);
		#1;
	endtask
	task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("compares %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// One whole bus cycle; the request drops once the cycle has started.
	task automatic run_cycle(input logic [2:0] k);
		dev_kind = k;
		cycle_req = 1'b1;
		do tick(); while (cycle_start !== 1'b1);
		cycle_req = 1'b0;
		chk("status", {2'h1, k}, {1'b0, bs});
		chk("kind", {2'h0, k}, {2'h0, ctl_kind});
		chk("strobes", tab[k], cmds);
		do tick(); while (cycle_end !== 1'b1);
		chk("strobes off", 5'h00, cmds);
	endtask
	// ----------
	// Clock, watchdog and tests
	// ----------
	always #4 clock = ~clock;
	// The tests need well under a thousand cycles, so this only cuts a hang.
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			stop_test();
		end
	end
	initial
	begin
		repeat (2) @(posedge clock);
		#1 sys_rst = 1'b0;
		tick();
		for (int k = 0; k < 7; k++)
			run_cycle(k[2:0]);
		$display("test kinds done");
		// Ready may only drop once the last cycle has left T3, or that cycle would wait for ever.
		do tick(); while (cycle_busy !== 1'b0);
		ready_in = 1'b0;
		run_cycle(3'h5);
		repeat (20) tick();
		chk("busy in wait", 5'h01, {4'h0, cycle_busy});
		chk("wait passive", 5'h0f, {1'b0, bs});
		ready_in = 1'b1;
		repeat (20) tick();
		chk("busy idle", 5'h00, {4'h0, cycle_busy});
		chk("idle passive", 5'h0f, {1'b0, bs});
		$display("test wait done");
		hold_req = 1'b1;
		do tick(); while (hold_ack !== 1'b1);
		chk("hold float", 5'h00, {4'h0, bs[3]});
		hold_req = 1'b0;
		do tick(); while (hold_ack !== 1'b0);
		run_cycle(3'h6);
		$display("test hold done");
		cpu_reset = 1'b1;
		repeat (2) tick();
		chk("reset drive", 5'h0f, {1'b0, bs});
		repeat (12) tick();
		chk("reset float", 5'h00, {4'h0, bs[3]});
		cpu_reset = 1'b0;
		repeat (12) tick();
		chk("after reset", 5'h0f, {1'b0, bs});
		run_cycle(3'h1);
		$display("test reset done");
		dev_kind = 3'h7;
		cycle_req = 1'b1;
		repeat (16) tick();
		cycle_req = 1'b0;
		chk("refused busy", 5'h00, {4'h0, cycle_busy});
		chk("refused passive", 5'h0f, {1'b0, bs});
		$display("test refuse done");
		stop_test();
	end
endmodule
`default_nettype wire
